// ### rtl/blt_consts.vh
/*
 constants for the boolean logic trigger recognizer: register offsets, field positions,
 reset values and timing counts.
 assumes a 10 mhz system clock and a 32-bit axi4-lite register port.
*/
`ifndef BLT_CONSTS_VH
`define BLT_CONSTS_VH
`define BLT_CLK_HZ 10000000
`define BLT_CHOP_HZ 1000000
`define BLT_CHOP_DIV (`BLT_CLK_HZ / `BLT_CHOP_HZ)
`define BLT_OFS_CTRL 8'h00
`define BLT_OFS_FUNCA 8'h04
`define BLT_OFS_FUNCB 8'h08
`define BLT_OFS_FILT 8'h0c
`define BLT_OFS_CHAN 8'h10
`define BLT_OFS_STAT 8'h14
`define BLT_CTRL_SELB 0
`define BLT_CTRL_NEST 1
`define BLT_CTRL_XCLK 2
`define BLT_CTRL_SLOPE 3
`define BLT_CTRL_MON 4
`define BLT_CTRL_CHOP 5
`define BLT_CTRL_RST 32'h00000000
`define BLT_FUNC_RST 32'h00000000
`define BLT_FUNCA_RST 32'h00000001
`define BLT_CHAN_RST 32'h00000001
`define BLT_TERM_X 3'h0
`define BLT_TERM_HI 3'h1
`define BLT_TERM_LO 3'h2
`define BLT_TERM_RISE 3'h3
`define BLT_TERM_FALL 3'h4
`define BLT_RESP_OKAY 2'h0
`define BLT_RESP_SLVERR 2'h2
`endif

// ### rtl/blt_match_func.v
/*
 one stored match function: two and-columns of four channel terms, or-ed together.
 assumes synchronized channel levels and their previous samples on the same clock.
*/
`default_nettype none
`include "blt_consts.vh"
module blt_match_func
(
    input wire [23:0] funcWord,
    input wire [3:0] chanNow,
    input wire [3:0] chanPrev,
    input wire [3:0] chanLive,
    output wire matchHit,
    output wire hasEdge
);
    wire [7:0] termOk;
    wire [7:0] termCare;
    wire [7:0] termEdge;
    genvar i;
    generate
        for (i = 0; i < 8; i = i + 1)
        begin : gTerm
            wire [2:0] code = funcWord[3*i +: 3];
            wire ch = chanNow[i % 4];
            wire pv = chanPrev[i % 4];
            // grounded channel is disconnected and cannot satisfy any term but don't care
            wire live = chanLive[i % 4];
            assign termOk[i] = (code == `BLT_TERM_X) ? 1'b1 :
                               (code == `BLT_TERM_HI) ? (live & ch) :
                               (code == `BLT_TERM_LO) ? (live & ~ch) :
                               (code == `BLT_TERM_RISE) ? (live & ch & ~pv) :
                               (code == `BLT_TERM_FALL) ? (live & ~ch & pv) : 1'b0;
            assign termCare[i] = (code != `BLT_TERM_X);
            assign termEdge[i] = (code == `BLT_TERM_RISE) || (code == `BLT_TERM_FALL);
        end
    endgenerate
    // an all-don't-care column stays inactive so it cannot make the or always true
    wire col0 = (&termOk[3:0]) & (|termCare[3:0]);
    wire col1 = (&termOk[7:4]) & (|termCare[7:4]);
    assign matchHit = col0 | col1;
    assign hasEdge = |termEdge;
endmodule // blt_match_func
`default_nettype wire

// ### rtl/blt_trigger.v
/*
 boolean logic trigger recognizer with axi4-lite registers.
 assumes chanIn, extClkIn and resetIn are asynchronous pins; everything else is on sys_clk.
*/
// What this block does
// - each term is high, low or don't care
// - a term may instead match a rising or falling edge
// - each column ands its four channel terms
// - the function ors its two columns
// - an all-don't-care column is inactive and gives false
// - functions a and b both stored; selected one drives the trigger
// - writing one function leaves the other unchanged
// - nested mode: a arms, next b triggers, never without arming
// - after a nested trigger, disarm and look for a again
// - monitor shows trigger output, or external clock when qualifying
// - monitor forced on when all channel displays are off
// - filter holds off output and drops events no longer than its count
// - filter bypassed for a function holding an edge term
// - filter bypass decided separately for a and b
// - filter bypassed with external clock qualify or zero setting
// - grounded channel feeds no match; display-off channel still does
// - alternate advances per sweep; chop switches near one megahertz
// - with qualify, trigger only on selected clock edge while match true
// - slope set picks rising clock edge, else falling
// - edge terms and external clock qualify are mutually exclusive
// - reset input forces match false and clears the armed state
`default_nettype none
`include "blt_consts.vh"
module blt_trigger
(
    input wire sys_clk,
    input wire sys_rst,
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    output wire [1:0] s_axi_bresp,
    output wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output wire [31:0] s_axi_rdata,
    output wire [1:0] s_axi_rresp,
    output wire s_axi_rvalid,
    input wire s_axi_rready,
    input wire [3:0] chanIn,
    input wire extClkIn,
    input wire resetIn,
    input wire sweepDone,
    output reg trigOut,
    output reg monitorTrace,
    output reg monitorOn,
    output reg [1:0] displayChan
);
    reg [31:0] ctrl_r;
    reg [23:0] funcA_r;
    reg [23:0] funcB_r;
    reg [15:0] filt_r;
    reg [7:0] chan_r;
    reg [3:0] chanS1_r, chanS2_r, chanPrev_r;
    reg xclkS1_r, xclkS2_r, xclkPrev_r;
    reg rstS1_r, rstS2_r;
    reg armed_r;
    reg [15:0] cntA_r, cntB_r;
    reg [3:0] chopCnt_r;
    reg [7:0] awaddr_r;
    reg [31:0] wdata_r;
    reg [3:0] wstrb_r;
    reg awHave_r, wHave_r, bvalid_r, rvalid_r;
    reg [1:0] bresp_r, rresp_r;
    reg [31:0] rdata_r;
    wire hitA, hitB, edgeA, edgeB;
    wire selB = ctrl_r[`BLT_CTRL_SELB];
    wire nest = ctrl_r[`BLT_CTRL_NEST];
    wire xclk = ctrl_r[`BLT_CTRL_XCLK];
    wire slope = ctrl_r[`BLT_CTRL_SLOPE];
    wire [3:0] dispEn = chan_r[3:0];
    wire [3:0] chanLive = ~chan_r[7:4];
    blt_match_func uFuncA
    (
        .funcWord(funcA_r),
        .chanNow(chanS2_r),
        .chanPrev(chanPrev_r),
        .chanLive(chanLive),
        .matchHit(hitA),
        .hasEdge(edgeA)
    );
    blt_match_func uFuncB
    (
        .funcWord(funcB_r),
        .chanNow(chanS2_r),
        .chanPrev(chanPrev_r),
        .chanLive(chanLive),
        .matchHit(hitB),
        .hasEdge(edgeB)
    );
    // pin synchronisers; previous sample taken from the second stage only
    always @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            chanS1_r <= 4'h0;
            chanS2_r <= 4'h0;
            chanPrev_r <= 4'h0;
            xclkS1_r <= 1'b0;
            xclkS2_r <= 1'b0;
            xclkPrev_r <= 1'b0;
            rstS1_r <= 1'b0;
            rstS2_r <= 1'b0;
        end
        else
        begin
            chanS1_r <= chanIn;
            chanS2_r <= chanS1_r;
            chanPrev_r <= chanS2_r;
            xclkS1_r <= extClkIn;
            xclkS2_r <= xclkS1_r;
            xclkPrev_r <= xclkS2_r;
            rstS1_r <= resetIn;
            rstS2_r <= rstS1_r;
        end
    end
    wire inhibit = rstS2_r;
    wire qualA = hitA & ~inhibit;
    wire qualB = hitB & ~inhibit;
    // per-function filter bypass
    wire filtOff = xclk || (filt_r == 16'h0000);
    wire bypA = filtOff || edgeA;
    wire bypB = filtOff || edgeB;
    // count must run the full setting before the output fires
    wire fireA = bypA ? qualA : (qualA && cntA_r == filt_r);
    wire fireB = bypB ? qualB : (qualB && cntB_r == filt_r);
    wire clkEdge = slope ? (xclkS2_r & ~xclkPrev_r) : (~xclkS2_r & xclkPrev_r);
    wire gateClk = ~xclk | clkEdge;
    wire evA = fireA & gateClk;
    wire evB = fireB & gateClk;
    wire trigNxt = nest ? (armed_r & evB) : (selB ? evB : evA);
    always @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            cntA_r <= 16'h0000;
            cntB_r <= 16'h0000;
            armed_r <= 1'b0;
            trigOut <= 1'b0;
            monitorTrace <= 1'b0;
            monitorOn <= 1'b0;
        end
        else
        begin
            // filter counters restart whenever the match drops
            cntA_r <= ~qualA ? 16'h0000 : (cntA_r == filt_r ? cntA_r : cntA_r + 16'h0001);
            cntB_r <= ~qualB ? 16'h0000 : (cntB_r == filt_r ? cntB_r : cntB_r + 16'h0001);
            if (!nest || inhibit)
                armed_r <= 1'b0;
            else if (armed_r && evB)
                armed_r <= 1'b0;
            else if (evA)
                armed_r <= 1'b1;
            trigOut <= trigNxt;
            monitorTrace <= xclk ? xclkS2_r : trigNxt;
            monitorOn <= ctrl_r[`BLT_CTRL_MON] | ~(|dispEn);
        end
    end
    // display sequencing: next enabled channel after a sweep or chop tick
    localparam [31:0] CHOP_LAST = `BLT_CHOP_DIV - 32'h1;
    localparam [31:0] FUNCA_RST = `BLT_FUNCA_RST;
    // low bits only: the divider stays well inside the four-bit counter
    wire chopTick = (chopCnt_r == CHOP_LAST[3:0]);
    wire advance = ctrl_r[`BLT_CTRL_CHOP] ? chopTick : sweepDone;
    reg [1:0] nextChan;
    always @*
    begin
        nextChan = displayChan;
        if (dispEn[displayChan + 2'h1])
            nextChan = displayChan + 2'h1;
        else if (dispEn[displayChan + 2'h2])
            nextChan = displayChan + 2'h2;
        else if (dispEn[displayChan + 2'h3])
            nextChan = displayChan + 2'h3;
    end
    always @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            chopCnt_r <= 4'h0;
            displayChan <= 2'h0;
        end
        else
        begin
            chopCnt_r <= chopTick ? 4'h0 : chopCnt_r + 4'h1;
            if (advance)
                displayChan <= nextChan;
        end
    end
    // axi4-lite slave: one write and one read at a time, address and data in either order
    assign s_axi_awready = ~awHave_r & ~bvalid_r;
    assign s_axi_wready = ~wHave_r & ~bvalid_r;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_arready = ~rvalid_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = rresp_r;
    wire [31:0] wmask = {{8{wstrb_r[3]}}, {8{wstrb_r[2]}}, {8{wstrb_r[1]}}, {8{wstrb_r[0]}}};
    wire [31:0] ctrlW = (ctrl_r & ~wmask) | (wdata_r & wmask);
    wire [31:0] funcAW = ({8'h00, funcA_r} & ~wmask) | (wdata_r & wmask);
    wire [31:0] funcBW = ({8'h00, funcB_r} & ~wmask) | (wdata_r & wmask);
    wire doWrite = awHave_r & wHave_r & ~bvalid_r;
    // reject edge terms while qualifying, and qualifying while any edge term is stored
    wire nextEdgeA = |{funcAW[23:21] == `BLT_TERM_RISE || funcAW[23:21] == `BLT_TERM_FALL,
        funcAW[20:18] == `BLT_TERM_RISE || funcAW[20:18] == `BLT_TERM_FALL,
        funcAW[17:15] == `BLT_TERM_RISE || funcAW[17:15] == `BLT_TERM_FALL,
        funcAW[14:12] == `BLT_TERM_RISE || funcAW[14:12] == `BLT_TERM_FALL,
        funcAW[11:9] == `BLT_TERM_RISE || funcAW[11:9] == `BLT_TERM_FALL,
        funcAW[8:6] == `BLT_TERM_RISE || funcAW[8:6] == `BLT_TERM_FALL,
        funcAW[5:3] == `BLT_TERM_RISE || funcAW[5:3] == `BLT_TERM_FALL,
        funcAW[2:0] == `BLT_TERM_RISE || funcAW[2:0] == `BLT_TERM_FALL};
    wire nextEdgeB = |{funcBW[23:21] == `BLT_TERM_RISE || funcBW[23:21] == `BLT_TERM_FALL,
        funcBW[20:18] == `BLT_TERM_RISE || funcBW[20:18] == `BLT_TERM_FALL,
        funcBW[17:15] == `BLT_TERM_RISE || funcBW[17:15] == `BLT_TERM_FALL,
        funcBW[14:12] == `BLT_TERM_RISE || funcBW[14:12] == `BLT_TERM_FALL,
        funcBW[11:9] == `BLT_TERM_RISE || funcBW[11:9] == `BLT_TERM_FALL,
        funcBW[8:6] == `BLT_TERM_RISE || funcBW[8:6] == `BLT_TERM_FALL,
        funcBW[5:3] == `BLT_TERM_RISE || funcBW[5:3] == `BLT_TERM_FALL,
        funcBW[2:0] == `BLT_TERM_RISE || funcBW[2:0] == `BLT_TERM_FALL};
    always @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            awHave_r <= 1'b0;
            wHave_r <= 1'b0;
            bvalid_r <= 1'b0;
            bresp_r <= `BLT_RESP_OKAY;
            awaddr_r <= 8'h00;
            wdata_r <= 32'h00000000;
            wstrb_r <= 4'h0;
            ctrl_r <= `BLT_CTRL_RST;
            funcA_r <= FUNCA_RST[23:0];
            funcB_r <= 24'h000000;
            filt_r <= 16'h0000;
            chan_r <= 8'h01;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                awHave_r <= 1'b1;
                awaddr_r <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                wHave_r <= 1'b1;
                wdata_r <= s_axi_wdata;
                wstrb_r <= s_axi_wstrb;
            end
            if (bvalid_r && s_axi_bready)
                bvalid_r <= 1'b0;
            if (doWrite)
            begin
                awHave_r <= 1'b0;
                wHave_r <= 1'b0;
                bvalid_r <= 1'b1;
                bresp_r <= `BLT_RESP_OKAY;
                case ({awaddr_r[7:2], 2'h0})
                    `BLT_OFS_CTRL:
                        if (ctrlW[`BLT_CTRL_XCLK] && !xclk && (edgeA || edgeB))
                            bresp_r <= `BLT_RESP_SLVERR;
                        else
                            ctrl_r <= {26'h0000000, ctrlW[5:0]};
                    `BLT_OFS_FUNCA:
                        if (xclk && nextEdgeA)
                            bresp_r <= `BLT_RESP_SLVERR;
                        else
                            funcA_r <= funcAW[23:0];
                    `BLT_OFS_FUNCB:
                        if (xclk && nextEdgeB)
                            bresp_r <= `BLT_RESP_SLVERR;
                        else
                            funcB_r <= funcBW[23:0];
                    `BLT_OFS_FILT:
                        filt_r <= (filt_r & ~wmask[15:0]) | (wdata_r[15:0] & wmask[15:0]);
                    `BLT_OFS_CHAN:
                        chan_r <= (chan_r & ~wmask[7:0]) | (wdata_r[7:0] & wmask[7:0]);
                    `BLT_OFS_STAT:
                        bresp_r <= `BLT_RESP_SLVERR;
                    default:
                        bresp_r <= `BLT_RESP_SLVERR;
                endcase
            end
        end
    end
    always @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            rvalid_r <= 1'b0;
            rdata_r <= 32'h00000000;
            rresp_r <= `BLT_RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            rvalid_r <= 1'b1;
            rresp_r <= `BLT_RESP_OKAY;
            case ({s_axi_araddr[7:2], 2'h0})
                `BLT_OFS_CTRL: rdata_r <= ctrl_r;
                `BLT_OFS_FUNCA: rdata_r <= {8'h00, funcA_r};
                `BLT_OFS_FUNCB: rdata_r <= {8'h00, funcB_r};
                `BLT_OFS_FILT: rdata_r <= {16'h0000, filt_r};
                `BLT_OFS_CHAN: rdata_r <= {24'h000000, chan_r};
                `BLT_OFS_STAT: rdata_r <= {22'h000000, displayChan, chanS2_r, monitorOn, edgeB, edgeA, armed_r};
                default:
                begin
                    rdata_r <= 32'h00000000;
                    rresp_r <= `BLT_RESP_SLVERR;
                end
            endcase
        end
        else if (rvalid_r && s_axi_rready)
            rvalid_r <= 1'b0;
    end
endmodule // blt_trigger
`default_nettype wire

// ### verif/blt_trigger_chk.sv
/* port checks for blt_trigger.
   assumes one sys_clk domain with async active-high sys_rst. */
`default_nettype none
module blt_trigger_chk
(
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic resetIn,
    input wire logic trigOut
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge sys_clk);
    endclocking
    default disable iff (sys_rst);
    // five samples leave room for the two sync flops and the output flop
    inhibit_hold_a: assert property (resetIn [*5] |-> !trigOut)
        else $error("trigger while inhibit held");
    write_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write answer dropped early");
    write_release_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write answer repeated");
    read_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read answer changed early");
    write_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while answer pending");
    read_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while answer pending");
    bresp_code_a: assert property (s_axi_bvalid |-> s_axi_bresp == 2'h0 || s_axi_bresp == 2'h2)
        else $error("bad write response code");
    write_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |-> ##[1:2] s_axi_bvalid) else $error("write answer late");
    read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
endmodule // blt_trigger_chk
bind blt_trigger blt_trigger_chk chk_i
(
    .sys_clk(sys_clk), .sys_rst(sys_rst),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .resetIn(resetIn), .trigOut(trigOut)
);
`default_nettype wire

// ### verif/blt_timebase_model.sv
/* time base model: a rising trigger starts a sweep of SWEEP_LEN cycles,
   ended by a one-cycle sweepDone. assumes the shared sys_clk. */
`default_nettype none
module blt_timebase_model
#(
    parameter int SWEEP_LEN = 12
)
(
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic trigOut,
    output logic sweepDone
);
    timeunit 1ns;
    timeprecision 1ns;
    int left;
    logic trigPrev;
    // no retrigger during a sweep, as a real time base holds off
    always @(posedge sys_clk or posedge sys_rst)
    begin
        trigPrev <= sys_rst ? 1'b0 : trigOut;
        sweepDone <= !sys_rst && left == 1;
        if (sys_rst)
            left <= 0;
        else if (left != 0)
            left <= left - 1;
        else if (trigOut && !trigPrev)
            left <= SWEEP_LEN;
    end
endmodule // blt_timebase_model
`default_nettype wire

// ### verif/blt_trigger_tb.sv
/* self-checking bench for blt_trigger beside the time base model.
   assumes blt_consts.vh on the include path. */
`default_nettype none
`include "blt_consts.vh"
module blt_trigger_tb;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct {logic [23:0] fw; logic [3:0] ch; logic ex;} blt_row_t;
    logic sys_clk = 0;
    logic sys_rst = 1;
    logic [7:0] s_axi_awaddr = 0;
    logic [7:0] s_axi_araddr = 0;
    logic [31:0] s_axi_wdata = 0;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 0;
    logic s_axi_wvalid = 0;
    logic s_axi_arvalid = 0;
    logic s_axi_bready = 1;
    logic s_axi_rready = 1;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic [3:0] chanIn = 0;
    logic extClkIn = 0;
    logic resetIn = 0;
    logic sweepDone, trigOut, monitorTrace, monitorOn;
    logic [1:0] displayChan;
    int fails = 0;
    int n_checks = 0;
    int c;
    logic trigS, monTS, monOnS;
    logic [1:0] dispS, dispOld;
    blt_row_t rows [9] = '{'{24'h000001, 4'h1, 1'b1}, '{24'h000001, 4'h0, 1'b0},
        '{24'h000002, 4'h0, 1'b1}, '{24'h000009, 4'h1, 1'b0}, '{24'h000009, 4'h3, 1'b1},
        '{24'h040001, 4'h4, 1'b1}, '{24'h000000, 4'hf, 1'b0}, '{24'h400000, 4'h0, 1'b1},
        '{24'h400000, 4'h8, 1'b0}};
    blt_trigger uut
    (
        .sys_clk(sys_clk), .sys_rst(sys_rst),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
        .chanIn(chanIn), .extClkIn(extClkIn), .resetIn(resetIn), .sweepDone(sweepDone),
        .trigOut(trigOut), .monitorTrace(monitorTrace), .monitorOn(monitorOn), .displayChan(displayChan)
    );
    blt_timebase_model tbm (.sys_clk(sys_clk), .sys_rst(sys_rst), .trigOut(trigOut), .sweepDone(sweepDone));
    initial
        forever #50 sys_clk = ~sys_clk;
    // outputs are judged from copies taken at the falling edge, where they have settled
    always @(negedge sys_clk)
    begin
        trigS <= trigOut;
        monTS <= monitorTrace;
        monOnS <= monitorOn;
        dispS <= displayChan;
    end
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_checks++;
        if (g !== e)
        begin
            fails++;
            $display("mismatch at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic give_verdict;
        $display("checks %0d, mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // bready and rready stay low until the answer shows, so the slave must hold it a cycle
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = 2'h0);
        logic hA, hW, hB;
        logic [1:0] r;
        hB = 0;
        s_axi_bready <= 0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1;
        s_axi_wvalid <= 1;
        while (!hB)
        begin
            @(negedge sys_clk);
            hA = s_axi_awvalid & s_axi_awready;
            hW = s_axi_wvalid & s_axi_wready;
            hB = s_axi_bvalid;
            r = s_axi_bresp;
            @(posedge sys_clk);
            if (hA) s_axi_awvalid <= 0;
            if (hW) s_axi_wvalid <= 0;
        end
        s_axi_bready <= 1;
        @(posedge sys_clk);
        chk(r, er);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        logic hA, hR;
        logic [31:0] d;
        hR = 0;
        s_axi_rready <= 0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1;
        while (!hR)
        begin
            @(negedge sys_clk);
            hA = s_axi_arvalid & s_axi_arready;
            hR = s_axi_rvalid;
            d = s_axi_rdata;
            @(posedge sys_clk);
            if (hA) s_axi_arvalid <= 0;
        end
        s_axi_rready <= 1;
        @(posedge sys_clk);
        chk(d, e);
    endtask
    task automatic cnt(input logic [3:0] ch, input int n, output int k);
        chanIn <= ch;
        k = 0;
        repeat (n)
        begin
            @(negedge sys_clk);
            k += trigOut;
            @(posedge sys_clk);
        end
    endtask
    task automatic tr(input logic [3:0] ch, input logic e);
        cnt(ch, 6, c);
        chk(trigS, e);
    endtask
    initial
    begin
        repeat (5000) @(posedge sys_clk);
        fails++;
        give_verdict;
    end
    initial
    begin
        repeat (5) @(posedge sys_clk);
        sys_rst <= 0;
        rd(`BLT_OFS_CTRL, `BLT_CTRL_RST);
        rd(`BLT_OFS_FUNCA, `BLT_FUNCA_RST);
        rd(`BLT_OFS_FUNCB, `BLT_FUNC_RST);
        rd(`BLT_OFS_CHAN, `BLT_CHAN_RST);
        foreach (rows[i])
        begin
            wr(`BLT_OFS_FUNCA, rows[i].fw);
            tr(rows[i].ch, rows[i].ex);
        end
        wr(`BLT_OFS_FUNCB, 2);
        rd(`BLT_OFS_FUNCA, 32'h400000);
        wr(`BLT_OFS_CTRL, 1);
        tr(0, 1);
        tr(1, 0);
        wr(`BLT_OFS_CTRL, 0);
        wr(`BLT_OFS_FUNCA, 1);
        wr(`BLT_OFS_CHAN, 8'h11);
        tr(1, 0);
        chk(monOnS, 0);
        wr(`BLT_OFS_CHAN, 0);
        tr(1, 1);
        chk(monOnS, 1);
        wr(`BLT_OFS_FUNCA, 3);
        wr(`BLT_OFS_CTRL, 4, `BLT_RESP_SLVERR);
        rd(`BLT_OFS_CTRL, 0);
        wr(8'h18, 0, `BLT_RESP_SLVERR);
        wr(`BLT_OFS_STAT, 0, `BLT_RESP_SLVERR);
        wr(`BLT_OFS_FILT, 4);
        for (int i = 3; i < 5; i++)
        begin
            wr(`BLT_OFS_FUNCA, i);
            cnt(i == 3 ? 4'h0 : 4'h1, 4, c);
            cnt(i == 3 ? 4'h1 : 4'h0, 8, c);
            chk(c, 1);
        end
        wr(`BLT_OFS_FUNCA, 1);
        cnt(1, 4, c);
        cnt(0, 10, c);
        chk(c, 0);
        cnt(1, 14, c);
        chk(c > 2, 1);
        wr(`BLT_OFS_FILT, 0);
        // let the sweep still running end while no display is enabled
        cnt(0, 16, c);
        wr(`BLT_OFS_CHAN, 3);
        cnt(1, 25, c);
        chk(dispS, 1);
        wr(`BLT_OFS_CTRL, 8'h20);
        dispOld = dispS;
        cnt(0, `BLT_CHOP_DIV, c);
        chk(dispS, dispOld ^ 2'h1);
        cnt(0, 4, c);
        wr(`BLT_OFS_FUNCB, 8);
        wr(`BLT_OFS_CTRL, 2);
        tr(2, 0);
        tr(1, 0);
        cnt(2, 8, c);
        chk(c != 0, 1);
        cnt(0, 4, c);
        cnt(2, 8, c);
        chk(c, 0);
        cnt(1, 4, c);
        resetIn <= 1;
        cnt(0, 6, c);
        resetIn <= 0;
        cnt(0, 4, c);
        cnt(2, 8, c);
        chk(c, 0);
        wr(`BLT_OFS_CTRL, 8'h10);
        tr(1, 1);
        chk(monTS, 1);
        tr(0, 0);
        chk(monTS, 0);
        wr(`BLT_OFS_CTRL, 8'h14);
        extClkIn <= 1;
        cnt(1, 8, c);
        chk(monTS, 1);
        chk(c, 0);
        extClkIn <= 0;
        cnt(1, 8, c);
        chk(monTS, 0);
        chk(c != 0, 1);
        wr(`BLT_OFS_CTRL, 8'h1c);
        extClkIn <= 1;
        cnt(1, 8, c);
        chk(c != 0, 1);
        give_verdict;
    end
endmodule // blt_trigger_tb
`default_nettype wire
